// file: hdl/mcio_pkg.sv
// Purpose: Shared constants for the parallel I/O port set
// Assumes: Byte-wide data-memory access, one instruction-cycle clock
// Notes:   All offsets and the port register reset values live here
package mcio_pkg;

    // ------------------------------------------------------------
    // Data-memory locations
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_L_OUTPUT = 8'hD0;
    localparam logic [7:0] ADDR_L_CONFIG = 8'hD1;
    localparam logic [7:0] ADDR_L_PINS   = 8'hD2;
    localparam logic [7:0] ADDR_G_OUTPUT = 8'hD4;
    localparam logic [7:0] ADDR_G_CONFIG = 8'hD5;
    localparam logic [7:0] ADDR_G_PINS   = 8'hD6;
    localparam logic [7:0] ADDR_I_PINS   = 8'hD7;
    localparam logic [7:0] ADDR_D_OUTPUT = 8'hDC;
    localparam logic [7:0] ADDR_C_OUTPUT = 8'hD8;
    localparam logic [7:0] ADDR_C_CONFIG = 8'hD9;
    localparam logic [7:0] ADDR_C_PINS   = 8'hDA;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_PORT_REG = 8'h00;
    localparam logic [7:0] RST_PORT_D   = 8'hFF;
    localparam logic [7:0] UNMAPPED_RD  = 8'h00;

    // ------------------------------------------------------------
    // Port G field positions
    // ------------------------------------------------------------
    localparam int G_EXT_IRQ_BIT   = 0;
    localparam int G_ERROR_BIT     = 1;
    localparam int G_T1_CAPT_BIT   = 2;
    localparam int G_T1_IO_BIT     = 3;
    localparam int G_SER_OUT_BIT   = 4;
    localparam int G_SER_CLK_BIT   = 5;
    localparam int G_IDLE_BIT      = 6;
    localparam int G_HALT_BIT      = 7;
    localparam int G_PHASE_BIT     = 6;
    localparam int G_DELAY_BIT     = 7;

    // ------------------------------------------------------------
    // Port L and I field positions
    // ------------------------------------------------------------
    localparam int L_EXT_CLK_BIT   = 1;
    localparam int L_TX_BIT        = 2;
    localparam int L_RX_BIT        = 3;
    localparam int L_T2A_BIT       = 4;
    localparam int L_T2B_BIT       = 5;
    localparam int L_T3A_BIT       = 6;
    localparam int L_T3B_BIT       = 7;
    localparam int I_C1_NEG_BIT    = 1;
    localparam int I_C1_POS_BIT    = 2;
    localparam int I_C1_OUT_BIT    = 3;
    localparam int I_C2_NEG_BIT    = 4;
    localparam int I_C2_POS_BIT    = 5;
    localparam int I_C2_OUT_BIT    = 6;

endpackage

// file: hdl/mcio_port_set.sv
// Purpose: Parallel I/O ports C, G, L, I and D with their memory locations
// Assumes: mclk is the instruction-cycle clock; pins are synchronous to it
// Notes:   Reads return data one cycle after mem_rd
`timescale 1ns/1ps

module mcio_port_set #(
    parameter int W = 8
) (
    input  wire logic         mclk,
    input  wire logic         srst,
    input  wire logic         ce,
    input  wire logic [7:0]   mem_addr,
    input  wire logic         mem_wr,
    input  wire logic [W-1:0] mem_wdata,
    input  wire logic         mem_bset,
    input  wire logic         mem_bclr,
    input  wire logic [2:0]   mem_bsel,
    input  wire logic         mem_rd,
    output logic      [W-1:0] mem_rdata,
    input  wire logic [W-1:0] port_l_in,
    output logic      [W-1:0] port_l_out,
    output logic      [W-1:0] port_l_oe,
    output logic      [W-1:0] port_l_pullup,
    input  wire logic [W-1:0] port_c_in,
    output logic      [W-1:0] port_c_out,
    output logic      [W-1:0] port_c_oe,
    output logic      [W-1:0] port_c_pullup,
    input  wire logic [W-1:0] port_g_in,
    output logic      [W-1:0] port_g_out,
    output logic      [W-1:0] port_g_oe,
    output logic      [W-1:0] port_g_pullup,
    input  wire logic [W-1:0] port_i_in,
    output logic              port_i_enable,
    output logic      [W-1:0] port_d_out,
    input  wire logic         xtal_option,
    input  wire logic         osc_clock,
    input  wire logic         supervisor_error_n,
    input  wire logic         serial_transmit_en,
    input  wire logic         serial_transmit_data,
    input  wire logic         serial_out_en,
    input  wire logic         serial_out_data,
    input  wire logic         timer1_out_en,
    input  wire logic         timer1_out_data,
    output logic              halt_request,
    output logic              idle_request,
    output logic              halt_exit,
    output logic              startup_delay_enable,
    output logic              serial_clock_phase_select,
    output logic      [W-1:0] multi_input_wakeup,
    output logic              serial_port_ext_clock,
    output logic              serial_receive_pin,
    output logic              timer2_input_a,
    output logic              timer2_input_b,
    output logic              timer3_input_a,
    output logic              timer3_input_b,
    output logic              serial_data_in,
    output logic              serial_clock_pin,
    output logic              timer1_io,
    output logic              timer1_capture_in,
    output logic              external_irq_in,
    output logic              comparator_one_neg_in,
    output logic              comparator_one_pos_in,
    output logic              comparator_one_output,
    output logic              comparator_two_neg_in,
    output logic              comparator_two_pos_in,
    output logic              comparator_two_output
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [W-1:0] cfg_l;
        logic [W-1:0] dat_l;
        logic [W-1:0] cfg_g;
        logic [W-1:0] dat_g;
        logic [W-1:0] cfg_c;
        logic [W-1:0] dat_c;
        logic [W-1:0] dat_d;
        logic [W-1:0] rdata;
        logic         g7_prev;
        logic         halt;
        logic         idle;
        logic         wake;
    } mcio_state_t;

    mcio_state_t st_r;
    mcio_state_t st_nxt;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Byte update for a whole write or a single-bit set or clear
    function automatic logic [W-1:0] upd(input logic [W-1:0] old);
        logic [W-1:0] m;
        m = '0;
        m[mem_bsel] = 1'b1;
        upd = old;
        if (mem_wr) begin
            upd = mem_wdata;
        end else if (mem_bset) begin
            upd = old | m;
        end else if (mem_bclr) begin
            upd = old & ~m;
        end
    endfunction

    function automatic logic hit(input logic [7:0] a);
        hit = (mem_addr == a) && (mem_wr || mem_bset || mem_bclr);
    endfunction

    logic [W-1:0] g_new;
    logic         g_touch;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt      = st_r;
        st_nxt.halt = 1'b0;
        st_nxt.idle = 1'b0;
        st_nxt.wake = 1'b0;
        g_touch     = hit(mcio_pkg::ADDR_G_OUTPUT);
        g_new       = upd(st_r.dat_g);
        if (hit(mcio_pkg::ADDR_L_CONFIG)) begin
            st_nxt.cfg_l = upd(st_r.cfg_l);
        end
        if (hit(mcio_pkg::ADDR_L_OUTPUT)) begin
            st_nxt.dat_l = upd(st_r.dat_l);
        end
        if (hit(mcio_pkg::ADDR_G_CONFIG)) begin
            st_nxt.cfg_g = upd(st_r.cfg_g);
        end
        if (hit(mcio_pkg::ADDR_C_CONFIG)) begin
            st_nxt.cfg_c = upd(st_r.cfg_c);
        end
        if (hit(mcio_pkg::ADDR_C_OUTPUT)) begin
            st_nxt.dat_c = upd(st_r.dat_c);
        end
        if (hit(mcio_pkg::ADDR_D_OUTPUT)) begin
            st_nxt.dat_d = upd(st_r.dat_d);
        end
        if (g_touch) begin
            // bits 6 and 7 not stored
            st_nxt.dat_g = g_new;
            st_nxt.dat_g[mcio_pkg::G_IDLE_BIT] = 1'b0;
            st_nxt.dat_g[mcio_pkg::G_HALT_BIT] = 1'b0;
            st_nxt.halt = g_new[mcio_pkg::G_HALT_BIT];
            st_nxt.idle = g_new[mcio_pkg::G_IDLE_BIT];
        end
        st_nxt.g7_prev = port_g_in[mcio_pkg::G_HALT_BIT];
        st_nxt.wake    = !xtal_option && !st_r.g7_prev
                         && port_g_in[mcio_pkg::G_HALT_BIT];
        if (mem_rd) begin
            case (mem_addr)
                mcio_pkg::ADDR_L_OUTPUT: st_nxt.rdata = st_r.dat_l;
                mcio_pkg::ADDR_L_CONFIG: st_nxt.rdata = st_r.cfg_l;
                mcio_pkg::ADDR_L_PINS:   st_nxt.rdata = port_l_in;
                mcio_pkg::ADDR_G_OUTPUT: st_nxt.rdata = st_r.dat_g;
                mcio_pkg::ADDR_G_CONFIG: st_nxt.rdata = st_r.cfg_g;
                mcio_pkg::ADDR_G_PINS:   st_nxt.rdata = port_g_in;
                mcio_pkg::ADDR_I_PINS:   st_nxt.rdata = port_i_in;
                mcio_pkg::ADDR_C_OUTPUT: st_nxt.rdata = st_r.dat_c;
                mcio_pkg::ADDR_C_CONFIG: st_nxt.rdata = st_r.cfg_c;
                mcio_pkg::ADDR_C_PINS:   st_nxt.rdata = port_c_in;
                mcio_pkg::ADDR_D_OUTPUT: st_nxt.rdata = st_r.dat_d;
                default:                 st_nxt.rdata = mcio_pkg::UNMAPPED_RD;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            st_r.cfg_l   <= mcio_pkg::RST_PORT_REG;
            st_r.dat_l   <= mcio_pkg::RST_PORT_REG;
            st_r.cfg_g   <= mcio_pkg::RST_PORT_REG;
            st_r.dat_g   <= mcio_pkg::RST_PORT_REG;
            st_r.cfg_c   <= mcio_pkg::RST_PORT_REG;
            st_r.dat_c   <= mcio_pkg::RST_PORT_REG;
            st_r.dat_d   <= mcio_pkg::RST_PORT_D;
            st_r.rdata   <= mcio_pkg::UNMAPPED_RD;
            st_r.g7_prev <= port_g_in[mcio_pkg::G_HALT_BIT];
            st_r.halt    <= 1'b0;
            st_r.idle    <= 1'b0;
            st_r.wake    <= 1'b0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Pin pair decode
    // ------------------------------------------------------------
    // Weak pull-up only on an input whose data bit is one
    function automatic logic pull_on(input logic cfg, input logic dat);
        pull_on = !cfg && dat;
    endfunction

    logic [W-1:0] l_pull;
    logic [W-1:0] c_pull;
    logic [W-1:0] g_pull;

    genvar b;
    generate
        for (b = 0; b < W; b = b + 1) begin : g_pair
            assign l_pull[b] = pull_on(st_r.cfg_l[b], st_r.dat_l[b]);
            assign c_pull[b] = pull_on(st_r.cfg_c[b], st_r.dat_c[b]);
            assign g_pull[b] = pull_on(st_r.cfg_g[b], st_r.dat_g[b]);
        end
    endgenerate

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    always_comb begin
        port_l_oe     = st_r.cfg_l;
        port_l_out    = st_r.dat_l;
        port_l_pullup = l_pull;
        port_c_oe     = st_r.cfg_c;
        port_c_out    = st_r.dat_c;
        port_c_pullup = c_pull;
        port_g_oe     = st_r.cfg_g;
        port_g_out    = st_r.dat_g;
        port_g_pullup = g_pull;
        if (serial_transmit_en) begin
            port_l_oe[mcio_pkg::L_TX_BIT]  = 1'b1;
            port_l_out[mcio_pkg::L_TX_BIT] = serial_transmit_data;
        end
        // serial out and timer 1 output
        if (serial_out_en) begin
            port_g_oe[mcio_pkg::G_SER_OUT_BIT]  = 1'b1;
            port_g_out[mcio_pkg::G_SER_OUT_BIT] = serial_out_data;
        end
        if (timer1_out_en) begin
            port_g_oe[mcio_pkg::G_T1_IO_BIT]  = 1'b1;
            port_g_out[mcio_pkg::G_T1_IO_BIT] = timer1_out_data;
        end
        port_g_oe[mcio_pkg::G_ERROR_BIT]     = !supervisor_error_n;
        port_g_out[mcio_pkg::G_ERROR_BIT]    = 1'b0;
        port_g_pullup[mcio_pkg::G_ERROR_BIT] = 1'b0;
        port_g_oe[mcio_pkg::G_IDLE_BIT]      = 1'b0;
        port_g_out[mcio_pkg::G_IDLE_BIT]     = 1'b0;
        port_g_pullup[mcio_pkg::G_IDLE_BIT]  = 1'b0;
        port_g_oe[mcio_pkg::G_HALT_BIT]      = xtal_option;
        port_g_out[mcio_pkg::G_HALT_BIT]     = xtal_option & osc_clock;
        port_g_pullup[mcio_pkg::G_HALT_BIT]  = 1'b0;
    end

    assign port_d_out = srst ? mcio_pkg::RST_PORT_D : st_r.dat_d;

    assign port_i_enable = (mem_addr == mcio_pkg::ADDR_I_PINS) && mem_rd;

    // ------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------
    assign mem_rdata    = st_r.rdata;
    assign halt_request = st_r.halt;
    assign idle_request = st_r.idle;
    assign halt_exit    = st_r.wake;

    // ------------------------------------------------------------
    // Mode controls
    // ------------------------------------------------------------
    // serial clock phase
    assign serial_clock_phase_select = st_r.cfg_g[mcio_pkg::G_PHASE_BIT];
    assign startup_delay_enable = st_r.cfg_g[mcio_pkg::G_DELAY_BIT] & ~xtal_option;

    // ------------------------------------------------------------
    // Alternate inputs
    // ------------------------------------------------------------
    // wakeup on every L pin
    assign multi_input_wakeup = port_l_in;

    assign serial_port_ext_clock = port_l_in[mcio_pkg::L_EXT_CLK_BIT];
    assign serial_receive_pin    = port_l_in[mcio_pkg::L_RX_BIT];
    assign timer2_input_a        = port_l_in[mcio_pkg::L_T2A_BIT];
    assign timer2_input_b        = port_l_in[mcio_pkg::L_T2B_BIT];
    assign timer3_input_a        = port_l_in[mcio_pkg::L_T3A_BIT];
    assign timer3_input_b        = port_l_in[mcio_pkg::L_T3B_BIT];

    assign serial_data_in    = port_g_in[mcio_pkg::G_IDLE_BIT];
    assign serial_clock_pin  = port_g_in[mcio_pkg::G_SER_CLK_BIT];
    assign timer1_io         = port_g_in[mcio_pkg::G_T1_IO_BIT];
    assign timer1_capture_in = port_g_in[mcio_pkg::G_T1_CAPT_BIT];
    assign external_irq_in   = port_g_in[mcio_pkg::G_EXT_IRQ_BIT];

    assign comparator_one_neg_in = port_i_in[mcio_pkg::I_C1_NEG_BIT];
    assign comparator_one_pos_in = port_i_in[mcio_pkg::I_C1_POS_BIT];
    assign comparator_one_output = port_i_in[mcio_pkg::I_C1_OUT_BIT];
    assign comparator_two_neg_in = port_i_in[mcio_pkg::I_C2_NEG_BIT];
    assign comparator_two_pos_in = port_i_in[mcio_pkg::I_C2_POS_BIT];
    assign comparator_two_output = port_i_in[mcio_pkg::I_C2_OUT_BIT];

endmodule

// file: tb/mcio_pin_model.sv
// Purpose: Board-side pin model for one 8-bit bidirectional port
// Assumes: Driver enables beat external drive, external drive beats pull-ups
// Notes:   Undriven pins without pull-up float as a toggling pattern
`timescale 1ns/1ps
module mcio_pin_model (
    input  wire logic       mclk,
    input  wire logic [7:0] oe,
    input  wire logic [7:0] drv,
    input  wire logic [7:0] pull_en,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] pins
);
    logic [7:0] flt_r = 8'h55;
    always @(posedge mclk) begin
        flt_r <= ~flt_r;
    end
    always_comb begin
        pins = (oe & drv) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & (pull_en | flt_r));
    end
endmodule

// file: tb/mcio_port_set_asserts.sv
// Purpose: Port-level checks of the parallel I/O port set
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to the top module after the checker
`timescale 1ns/1ps
module mcio_port_set_asserts #(
    parameter int W = 8
) (
    input wire logic         mclk,
    input wire logic         srst,
    input wire logic         ce,
    input wire logic [7:0]   mem_addr,
    input wire logic         mem_wr,
    input wire logic [W-1:0] mem_wdata,
    input wire logic         mem_bset,
    input wire logic         mem_rd,
    input wire logic [W-1:0] mem_rdata,
    input wire logic [W-1:0] port_l_in,
    input wire logic [W-1:0] port_l_oe,
    input wire logic [W-1:0] port_g_in,
    input wire logic [W-1:0] port_g_out,
    input wire logic [W-1:0] port_g_oe,
    input wire logic [W-1:0] port_d_out,
    input wire logic         xtal_option,
    input wire logic         osc_clock,
    input wire logic         supervisor_error_n,
    input wire logic         halt_request,
    input wire logic         idle_request,
    input wire logic         halt_exit,
    input wire logic         startup_delay_enable,
    input wire logic         serial_clock_phase_select
);
    logic g_wr;
    logic g_set;
    assign g_wr = ce && mem_wr && mem_addr == mcio_pkg::ADDR_G_OUTPUT;
    assign g_set = ce && (mem_wr || mem_bset) && mem_addr == mcio_pkg::ADDR_G_OUTPUT;
    default clocking cb @(posedge mclk);
    endclocking
    a_lcfg_drive: assert property (disable iff (srst)
        ce && mem_wr && mem_addr == mcio_pkg::ADDR_L_CONFIG |=>
        (port_l_oe & 8'hFB) == ($past(mem_wdata) & 8'hFB)) else $error("drive enable wrong");
    a_halt_pulse: assert property (disable iff (srst)
        g_wr && mem_wdata[7] |=> halt_request ##1 !halt_request) else $error("halt pulse wrong");
    a_idle_pulse: assert property (disable iff (srst)
        g_wr && mem_wdata[6] |=> idle_request ##1 !idle_request) else $error("idle pulse wrong");
    a_halt_cause: assert property (disable iff (srst)
        halt_request |-> $past(g_set)) else $error("halt without write");
    a_g_read_zero: assert property (disable iff (srst)
        ce && mem_rd && mem_addr == mcio_pkg::ADDR_G_OUTPUT |=> mem_rdata[7:6] == 2'h0)
        else $error("G data high bits not zero");
    a_pin_read: assert property (disable iff (srst)
        ce && mem_rd && mem_addr == mcio_pkg::ADDR_L_PINS |=> mem_rdata == $past(port_l_in))
        else $error("pin read wrong");
    a_phase_cfg: assert property (disable iff (srst)
        ce && mem_wr && mem_addr == mcio_pkg::ADDR_G_CONFIG |=>
        serial_clock_phase_select == $past(mem_wdata[6])) else $error("phase select wrong");
    a_delay_gate: assert property (disable iff (srst)
        startup_delay_enable |-> !xtal_option) else $error("delay enable with crystal");
    a_osc_pass: assert property (disable iff (srst)
        xtal_option |-> port_g_oe[7] && port_g_out[7] == osc_clock) else $error("clock out wrong");
    a_halt_exit: assert property (disable iff (srst)
        ce && !xtal_option && !$past(srst) && $rose(port_g_in[7]) |=> halt_exit)
        else $error("halt exit missing");
    a_error_pin: assert property (disable iff (srst)
        !supervisor_error_n |-> port_g_oe[1] && !port_g_out[1]) else $error("error pin wrong");
    a_d_preset: assert property (
        srst |-> port_d_out == 8'hFF) else $error("port D not high in reset");
endmodule

bind mcio_port_set mcio_port_set_asserts #(.W(W)) mcio_port_set_asserts_inst (.mclk, .srst,
    .ce, .mem_addr, .mem_wr, .mem_wdata, .mem_bset, .mem_rd, .mem_rdata, .port_l_in,
    .port_l_oe, .port_g_in, .port_g_out, .port_g_oe, .port_d_out, .xtal_option, .osc_clock,
    .supervisor_error_n, .halt_request, .idle_request, .halt_exit, .startup_delay_enable,
    .serial_clock_phase_select);

// file: tb/mcu_io_port_set_tb.sv
// Purpose: Self-checking bench for the parallel I/O port set
// Assumes: Pin models on ports L, C and G; port I driven directly
// Notes:   Access op code is {write, bit set, bit clear, read}
`timescale 1ns/1ps
module mcu_io_port_set_tb;
    logic mclk = 1'b0, srst = 1'b1, ce = 1'b1, mem_wr = 1'b0, mem_bset = 1'b0;
    logic mem_bclr = 1'b0, mem_rd = 1'b0, xtal_option = 1'b0, osc_clock = 1'b0;
    logic supervisor_error_n = 1'b1;
    logic [2:0] mem_bsel = 3'h0;
    logic [5:0] ovr = 6'h00;
    logic [7:0] mem_addr = 8'h00, mem_wdata = 8'h00, port_i_in = 8'h00;
    logic [7:0] l_xv = 8'h00, c_xv = 8'h00, g_xv = 8'h00;
    logic [7:0] mem_rdata, port_l_in, port_l_out, port_l_oe, port_l_pullup, port_c_in;
    logic [7:0] port_c_out, port_c_oe, port_c_pullup, port_g_in, port_g_out, port_g_oe;
    logic [7:0] port_g_pullup, port_d_out, multi_input_wakeup;
    logic [16:0] alt;
    logic port_i_enable, halt_request, idle_request, halt_exit, startup_delay_enable;
    logic serial_clock_phase_select;
    int num_errors = 0;
    int num_checks = 0;

    always #25 mclk = ~mclk;
    always @(posedge mclk) osc_clock <= ~osc_clock;

    mcio_port_set mcio_port_set_inst (.mclk, .srst, .ce, .mem_addr, .mem_wr, .mem_wdata,
        .mem_bset, .mem_bclr, .mem_bsel, .mem_rd, .mem_rdata, .port_l_in, .port_l_out,
        .port_l_oe, .port_l_pullup, .port_c_in, .port_c_out, .port_c_oe, .port_c_pullup,
        .port_g_in, .port_g_out, .port_g_oe, .port_g_pullup, .port_i_in, .port_i_enable,
        .port_d_out, .xtal_option, .osc_clock, .supervisor_error_n,
        .serial_transmit_en(ovr[5]), .serial_transmit_data(ovr[4]), .serial_out_en(ovr[3]),
        .serial_out_data(ovr[2]), .timer1_out_en(ovr[1]), .timer1_out_data(ovr[0]),
        .halt_request, .idle_request, .halt_exit, .startup_delay_enable,
        .serial_clock_phase_select, .multi_input_wakeup, .serial_port_ext_clock(alt[0]),
        .serial_receive_pin(alt[1]), .timer2_input_a(alt[2]), .timer2_input_b(alt[3]),
        .timer3_input_a(alt[4]), .timer3_input_b(alt[5]), .serial_data_in(alt[6]),
        .serial_clock_pin(alt[7]), .timer1_io(alt[8]), .timer1_capture_in(alt[9]),
        .external_irq_in(alt[10]), .comparator_one_neg_in(alt[11]),
        .comparator_one_pos_in(alt[12]), .comparator_one_output(alt[13]),
        .comparator_two_neg_in(alt[14]), .comparator_two_pos_in(alt[15]),
        .comparator_two_output(alt[16]));
    mcio_pin_model pm_l (.mclk, .oe(port_l_oe), .drv(port_l_out), .pull_en(port_l_pullup),
        .ext_en(8'hFF), .ext_val(l_xv), .pins(port_l_in));
    mcio_pin_model pm_c (.mclk, .oe(port_c_oe), .drv(port_c_out), .pull_en(port_c_pullup),
        .ext_en(8'hFF), .ext_val(c_xv), .pins(port_c_in));
    mcio_pin_model pm_g (.mclk, .oe(port_g_oe), .drv(port_g_out), .pull_en(port_g_pullup),
        .ext_en(8'hFF), .ext_val(g_xv), .pins(port_g_in));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic mem(input logic [7:0] a, input logic [3:0] op, input logic [7:0] d);
        @(posedge mclk);
        mem_addr <= a;
        {mem_wr, mem_bset, mem_bclr, mem_rd} <= op;
        mem_wdata <= d;
        mem_bsel <= d[2:0];
        @(posedge mclk);
        {mem_wr, mem_bset, mem_bclr, mem_rd} <= 4'h0;
        #1;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        mem(a, 4'h1, 8'h00);
        chk(mem_rdata, exp);
    endtask
    task automatic cyc;
        @(posedge mclk);
        #1;
    endtask

    task automatic t_reset;
        chk({port_l_oe, port_l_pullup, port_c_oe, port_d_out}, 32'h000000FF);
        @(posedge mclk);
        srst <= 1'b0;
        rdc(mcio_pkg::ADDR_L_CONFIG, 8'h00);
        rdc(mcio_pkg::ADDR_G_OUTPUT, 8'h00);
        rdc(mcio_pkg::ADDR_C_CONFIG, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_modes;
        mem(mcio_pkg::ADDR_L_CONFIG, 4'h8, 8'h33);
        mem(mcio_pkg::ADDR_L_OUTPUT, 4'h8, 8'h56);
        chk({port_l_oe, port_l_pullup, port_l_out & port_l_oe}, 32'h334412);
        rdc(mcio_pkg::ADDR_L_PINS, 8'h12);
        mem(mcio_pkg::ADDR_L_PINS, 4'h8, 8'hFF);
        rdc(mcio_pkg::ADDR_L_OUTPUT, 8'h56);
        rdc(8'hD3, 8'h00);
        mem(mcio_pkg::ADDR_C_CONFIG, 4'h4, 8'h05);
        mem(mcio_pkg::ADDR_C_OUTPUT, 4'h4, 8'h05);
        chk({port_c_oe, port_c_out & port_c_oe}, 32'h2020);
        mem(mcio_pkg::ADDR_C_CONFIG, 4'h2, 8'h05);
        rdc(mcio_pkg::ADDR_C_CONFIG, 8'h00);
        chk(port_c_pullup, 8'h20);
        @(posedge mclk);
        ce <= 1'b0;
        mem(mcio_pkg::ADDR_C_OUTPUT, 4'h8, 8'hFF);
        @(posedge mclk);
        ce <= 1'b1;
        rdc(mcio_pkg::ADDR_C_OUTPUT, 8'h20);
        $display("test modes done");
    endtask
    task automatic t_gport;
        mem(mcio_pkg::ADDR_G_OUTPUT, 4'h8, 8'hC0);
        chk({halt_request, idle_request}, 2'h3);
        cyc();
        chk({halt_request, idle_request}, 2'h0);
        rdc(mcio_pkg::ADDR_G_OUTPUT, 8'h00);
        mem(mcio_pkg::ADDR_G_OUTPUT, 4'h8, 8'h3F);
        chk(port_g_pullup, 8'h3D);
        mem(mcio_pkg::ADDR_G_OUTPUT, 4'h4, 8'h07);
        chk({halt_request, idle_request}, 2'h2);
        mem(mcio_pkg::ADDR_G_CONFIG, 4'h8, 8'hC0);
        chk({startup_delay_enable, serial_clock_phase_select}, 2'h3);
        @(posedge mclk);
        xtal_option <= 1'b1;
        cyc();
        chk({startup_delay_enable, port_g_oe[7], port_g_out[7] ^ osc_clock}, 3'h2);
        @(posedge mclk);
        xtal_option <= 1'b0;
        @(posedge mclk);
        g_xv <= 8'h80;
        cyc();
        chk(halt_exit, 1'b1);
        cyc();
        chk(halt_exit, 1'b0);
        @(posedge mclk);
        supervisor_error_n <= 1'b0;
        cyc();
        chk({port_g_oe[1], port_g_out[1]}, 2'h2);
        @(posedge mclk);
        supervisor_error_n <= 1'b1;
        cyc();
        chk(port_g_oe[1], 1'b0);
        $display("test port G done");
    endtask
    task automatic t_alt;
        logic [7:0] l;
        logic [7:0] g;
        logic [7:0] i;
        l = 8'hA6;
        g = 8'hCD;
        i = 8'hDB;
        mem(mcio_pkg::ADDR_L_CONFIG, 4'h8, 8'h00);
        @(posedge mclk);
        l_xv <= l;
        g_xv <= g;
        port_i_in <= i;
        ovr <= 6'h3F;
        mem_addr <= mcio_pkg::ADDR_I_PINS;
        mem_rd <= 1'b1;
        #1;
        chk(port_i_enable, 1'b1);
        @(posedge mclk);
        mem_rd <= 1'b0;
        #1;
        chk(mem_rdata & 8'h7E, i & 8'h7E);
        chk(port_i_enable, 1'b0);
        chk(multi_input_wakeup, l);
        chk(alt, {i[6:1], g[0], g[2], g[3], g[5], g[6], l[7:4], l[3], l[1]});
        chk({port_l_oe[2], port_l_out[2], port_g_oe[4:3], port_g_out[4:3]}, 6'h3F);
        $display("test alternates done");
    endtask
    task automatic t_portd;
        mem(mcio_pkg::ADDR_D_OUTPUT, 4'h8, 8'h3C);
        chk(port_d_out, 8'h3C);
        @(posedge mclk);
        srst <= 1'b1;
        #1;
        chk(port_d_out, 8'hFF);
        @(posedge mclk);
        srst <= 1'b0;
        cyc();
        chk(halt_exit, 1'b0);
        rdc(mcio_pkg::ADDR_C_OUTPUT, 8'h00);
        $display("test port D done");
    endtask
    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge mclk);
        #1;
        t_reset();
        t_modes();
        t_gport();
        t_alt();
        t_portd();
        report_and_stop();
    end
    initial begin
        repeat (3000) @(posedge mclk);
        num_errors++;
        report_and_stop();
    end
endmodule
